// ---- rtl/level_sync.sv ----
// Two-stage synchroniser for quasi-static levels and gray-coded words.
// Assumes the source changes at most one bit at a time or holds long enough.
`timescale 1ns/1ps
`default_nettype none
module level_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   // ==========================================================================
   // The first stage is read by the second stage only.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/line_io_params.svh ----
// Constants for the line-side port pin block: register map, field positions, reset values.
// Assumes inclusion by the package and by every design file that decodes registers.
`ifndef LINE_IO_PARAMS_SVH
`define LINE_IO_PARAMS_SVH

// ==========================================================================
// Register map.
`define ADDR_CTRL 12'h000
`define ADDR_VIOL_COUNT 12'h004
`define CTRL_WIDTH 8
`define CTRL_RESET 8'h00
`define COUNT_WIDTH 16
`define SYNC_STAGES 2

// ==========================================================================
// Control field positions.
`define BIT_UNIPOLAR 0
`define BIT_TX_PINS_EN 1
`define BIT_FRONTEND_EN 2
`define BIT_RX_SERIAL_EN 3
`define BIT_TX_CLK_INV 4
`define BIT_TX_DATA_INV 5
`define BIT_RX_CLK_INV 6
`define BIT_RX_DATA_INV 7

`endif

// ---- rtl/line_io_pkg.sv ----
// Types shared by the line-side port pin block.
// Assumes the constants header is on the include path.
package line_io_pkg;
`include "line_io_params.svh"

   typedef struct packed {
      logic rx_data_inv;
      logic rx_clk_inv;
      logic tx_data_inv;
      logic tx_clk_inv;
      logic rx_serial_en;
      logic frontend_en;
      logic tx_pins_en;
      logic unipolar_mode;
   } cfg_s;

   typedef struct packed {
      logic pos;
      logic neg;
   } rail_s;

   typedef enum logic [1:0] {
      TX_LOW = 2'b01,
      TX_HIGH = 2'b10
   } tx_phase_e;
endpackage

// ---- rtl/line_side_digital_port_io.sv ----
// Line-side pin interface of one port: bipolar rails, unipolar data, polarity options, APB control.
// Assumes core transmit bits arrive on pclk; receive pins are timed to rx_line_clock_in.
`timescale 1ns/1ps
`default_nettype none
`include "line_io_params.svh"

// Summary of operation
// RQ1: Digital tx rails drive only in bipolar mode with tx pins enabled; the line clock drives whenever tx pins are enabled.
// RQ2: Digital tx pins may run together with the analog line driver.
// RQ3: Tx rails change after the clock pin rising edge, or falling when inverted.
// RQ4: The far receiver normally times tx rails from the tx line clock.
// RQ5: Digital tx rails may be inverted; analog tx outputs never are.
// RQ6: Analog tx outputs drive only in bipolar mode with the analog front end on.
// RQ7: Rx rails are used only in bipolar mode with front end off; the line clock times the receive side in every mode.
// RQ8: Rx serial output carries the decoded received bits after a short delay.
// RQ9: Rx rails are sampled on the rising line clock edge, falling when inverted.
// RQ10: Rx line clock alone times rx rails; both rails may be inverted.
// RQ11: Unipolar tx data drives only in unipolar mode with tx pins enabled.
// RQ12: Unipolar tx data changes on the selected clock edge and may be inverted.
// RQ13: Unipolar rx data and violation inputs are used only in unipolar mode.
// RQ14: In unipolar mode every received bit reaches the enabled rx serial output.
// RQ15: The violation counter gains one for each line clock with violation high.
// RQ16: Unipolar rx inputs are sampled on the selected edge and may be inverted.
// RQ17: Each polarity option is a separate control bit, non-inverted after reset.
module line_side_digital_port_io
import line_io_pkg::*;
#(
   parameter int COUNT_W = `COUNT_WIDTH
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_pos_in,
   input wire logic tx_neg_in,
   output logic tx_bit_take,
   output logic tx_pos_rail_out,
   output logic tx_neg_rail_out,
   output logic tx_line_clock_out,
   output logic tx_unipolar_data_out,
   output logic tx_analog_pos_out,
   output logic tx_analog_neg_out,
   input wire logic rx_line_clock_in,
   input wire logic rx_pos_rail_in,
   input wire logic rx_neg_rail_in,
   input wire logic rx_analog_pos_in,
   input wire logic rx_analog_neg_in,
   input wire logic rx_unipolar_data_in,
   input wire logic rx_code_violation_in,
   output logic rx_serial_data_out
);

   // ==========================================================================
   // APB register slave.
   logic [`CTRL_WIDTH-1:0] ctrl_reg;
   cfg_s cfg;
   wire logic access = psel && penable;
   wire logic done = access && pready;
   wire logic hit_ctrl = (paddr == `ADDR_CTRL);
   wire logic hit_count = (paddr == `ADDR_VIOL_COUNT);
   wire logic hit_any = hit_ctrl || hit_count;
   wire logic [COUNT_W-1:0] count_pclk;
   logic [31:0] rdata_next;

   assign cfg = cfg_s'(ctrl_reg);

   always_comb
   begin
      if (hit_ctrl)
      begin
         rdata_next = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_reg};
      end
      else if (hit_count)
      begin
         rdata_next = {{(32-COUNT_W){1'b0}}, count_pclk};
      end
      else
      begin
         rdata_next = 32'h0000_0000;
      end
   end

   // One wait state: pready rises in the second access cycle, so data is registered.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= `CTRL_RESET; // RQ17
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (ce)
      begin
         pready <= access && !pready;
         prdata <= (access && !pready && !pwrite) ? rdata_next : 32'h0000_0000;
         pslverr <= access && !pready && !hit_any;
         if (done && pwrite && hit_ctrl)
         begin
            ctrl_reg <= pwdata[`CTRL_WIDTH-1:0]; // RQ17
         end
      end
   end

   // ==========================================================================
   // Transmit side, timed from pclk; the clock pin is a divided copy of it.
   tx_phase_e phase_reg;
   tx_phase_e phase_next;
   wire logic bip_pins = !cfg.unipolar_mode && cfg.tx_pins_en;
   wire logic uni_pins = cfg.unipolar_mode && cfg.tx_pins_en;
   wire logic analog_on = !cfg.unipolar_mode && cfg.frontend_en;
   wire logic take = (phase_reg == TX_LOW);

   always_comb
   begin
      case (phase_reg)
         TX_LOW: phase_next = TX_HIGH;
         TX_HIGH: phase_next = TX_LOW;
         default: phase_next = TX_LOW;
      endcase
   end

   // Gating is applied every cycle with ce high so a pin falls silent at once when disabled.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_reg <= TX_LOW;
         tx_bit_take <= 1'b0;
         tx_line_clock_out <= 1'b0;
         tx_pos_rail_out <= 1'b0;
         tx_neg_rail_out <= 1'b0;
         tx_unipolar_data_out <= 1'b0;
         tx_analog_pos_out <= 1'b0;
         tx_analog_neg_out <= 1'b0;
      end
      else if (ce)
      begin
         phase_reg <= phase_next;
         tx_bit_take <= take;
         tx_line_clock_out <= cfg.tx_pins_en && ((phase_next == TX_HIGH) ^ cfg.tx_clk_inv); // RQ3
         if (!bip_pins)
         begin
            tx_pos_rail_out <= 1'b0; // RQ1
            tx_neg_rail_out <= 1'b0; // RQ1
         end
         else if (take)
         begin
            tx_pos_rail_out <= tx_pos_in ^ cfg.tx_data_inv; // RQ5
            tx_neg_rail_out <= tx_neg_in ^ cfg.tx_data_inv; // RQ5
         end
         if (!uni_pins)
         begin
            tx_unipolar_data_out <= 1'b0; // RQ11
         end
         else if (take)
         begin
            tx_unipolar_data_out <= tx_pos_in ^ cfg.tx_data_inv; // RQ12
         end
         // The analog pair is independent of the digital pins and never inverted.
         if (!analog_on)
         begin
            tx_analog_pos_out <= 1'b0; // RQ6
            tx_analog_neg_out <= 1'b0; // RQ6
         end
         else if (take)
         begin
            tx_analog_pos_out <= tx_pos_in; // RQ2
            tx_analog_neg_out <= tx_neg_in; // RQ2
         end
      end
   end

   // ==========================================================================
   // Control levels into the receive domain.
   // Reconfiguring while traffic runs may corrupt a bit or two during the crossing.
   wire logic [`CTRL_WIDTH:0] cfg_rx_raw;
   cfg_s rcfg;
   logic rce;

   level_sync #(.WIDTH(`CTRL_WIDTH + 1)) u_cfg_sync
   (
      .clk(rx_line_clock_in),
      .rst_n(presetn),
      .d({ce, ctrl_reg}),
      .q(cfg_rx_raw)
   );

   assign rcfg = cfg_s'(cfg_rx_raw[`CTRL_WIDTH-1:0]);
   assign rce = cfg_rx_raw[`CTRL_WIDTH];

   // ==========================================================================
   // Receive side, on the line clock.
   wire logic rx_bip_dig = !rcfg.unipolar_mode && !rcfg.frontend_en;
   wire logic rx_bip_ana = !rcfg.unipolar_mode && rcfg.frontend_en;
   rail_s raw_pair;
   rail_s rise_smp_reg;
   rail_s fall_smp_reg;
   rail_s sel_pair;
   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] count_next;
   logic [COUNT_W-1:0] gray_reg;

   always_comb
   begin
      if (rcfg.unipolar_mode)
      begin
         raw_pair = '{pos: rx_unipolar_data_in, neg: rx_code_violation_in}; // RQ13
      end
      else if (rx_bip_dig)
      begin
         raw_pair = '{pos: rx_pos_rail_in, neg: rx_neg_rail_in}; // RQ7
      end
      else
      begin
         raw_pair = '{pos: rx_analog_pos_in, neg: rx_analog_neg_in};
      end
   end

   // The line clock is the only reference for these pins; both edges are captured.
   always_ff @(posedge rx_line_clock_in or negedge presetn)
   begin
      if (!presetn)
      begin
         rise_smp_reg <= '0;
      end
      else if (rce)
      begin
         rise_smp_reg <= raw_pair; // RQ10
      end
   end

   always_ff @(negedge rx_line_clock_in or negedge presetn)
   begin
      if (!presetn)
      begin
         fall_smp_reg <= '0;
      end
      else if (rce)
      begin
         fall_smp_reg <= raw_pair; // RQ10
      end
   end

   wire logic rx_inv = rcfg.rx_data_inv && !rx_bip_ana;
   assign sel_pair = (rcfg.rx_clk_inv ? fall_smp_reg : rise_smp_reg) ^ {rx_inv, rx_inv}; // RQ9 RQ16
   wire logic rx_bit = rcfg.unipolar_mode ? sel_pair.pos : (sel_pair.pos || sel_pair.neg); // RQ8
   wire logic viol = rcfg.unipolar_mode && sel_pair.neg; // RQ15

   assign count_next = count_reg + COUNT_W'(viol);

   always_ff @(posedge rx_line_clock_in or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_serial_data_out <= 1'b0;
         count_reg <= '0;
         gray_reg <= '0;
      end
      else if (rce)
      begin
         rx_serial_data_out <= rcfg.rx_serial_en && rx_bit; // RQ14
         count_reg <= count_next; // RQ15
         gray_reg <= count_next ^ (count_next >> 1);
      end
   end

   // ==========================================================================
   // Violation count back to pclk as gray code.
   wire logic [COUNT_W-1:0] gray_pclk;

   level_sync #(.WIDTH(COUNT_W)) u_count_sync
   (
      .clk(pclk),
      .rst_n(presetn),
      .d(gray_reg),
      .q(gray_pclk)
   );

   function automatic logic [COUNT_W-1:0] gray_to_bin(input logic [COUNT_W-1:0] g);
      logic [COUNT_W-1:0] b;
      b = '0;
      for (int i = COUNT_W - 1; i >= 0; i--)
      begin
         b[i] = g[i] ^ ((i == COUNT_W - 1) ? 1'b0 : b[i+1]);
      end
      return b;
   endfunction

   assign count_pclk = gray_to_bin(gray_pclk);

   // ==========================================================================
   // Checks.
   a_tx_rail_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
      ce && !bip_pins |=> !tx_pos_rail_out && !tx_neg_rail_out)
      else $error("tx rails driven while unavailable");

   a_analog_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      ce && !analog_on |=> !tx_analog_pos_out && !tx_analog_neg_out)
      else $error("analog tx driven while front end off");

   a_uni_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      ce && !uni_pins |=> !tx_unipolar_data_out)
      else $error("unipolar tx driven while unavailable");

   a_tx_clock_edge: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      ce && take && cfg.tx_pins_en ##1 ce |-> tx_bit_take && (tx_line_clock_out != $past(cfg.tx_clk_inv))
      ##1 (tx_line_clock_out == $past(cfg.tx_clk_inv)))
      else $error("tx clock pin edge not aligned to rail update");

   a_tx_polarity: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      ce && take && bip_pins |=> tx_pos_rail_out == ($past(tx_pos_in) ^ $past(cfg.tx_data_inv))
      && tx_neg_rail_out == ($past(tx_neg_in) ^ $past(cfg.tx_data_inv)))
      else $error("tx rail polarity wrong");

   a_viol_count: assert property (@(posedge rx_line_clock_in) disable iff (!presetn) // RQ15
      rce && viol |=> count_reg == $past(count_reg) + COUNT_W'(1))
      else $error("violation not counted");

   a_rx_serial: assert property (@(posedge rx_line_clock_in) disable iff (!presetn) // RQ14
      rce && rcfg.rx_serial_en && rcfg.unipolar_mode |=> rx_serial_data_out == $past(sel_pair.pos))
      else $error("unipolar rx bit lost");

   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      ce && access && !pready ##1 ce |-> pready ##1 !pready)
      else $error("apb ready not one cycle after access");

   a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
      ce && done && pwrite && hit_ctrl |=> ctrl_reg == $past(pwdata[`CTRL_WIDTH-1:0]))
      else $error("control write lost");
endmodule
`default_nettype wire

// ---- test/line_partner.sv ----
// Far-side line model: a free-running receive line clock and random line traffic.
// Assumes the bench gives the sampling edge choice and the idle level of the violation pin.
`timescale 1ns/1ps
`default_nettype none
module line_partner
(
   input wire logic run,
   input wire logic clk_inv,
   input wire logic lcv_idle,
   output logic rx_line_clock_in,
   output logic rx_pos_rail_in,
   output logic rx_neg_rail_in,
   output logic rx_analog_pos_in,
   output logic rx_analog_neg_in,
   output logic rx_unipolar_data_in,
   output logic rx_code_violation_in
);
   integer seed = 32'hd6dcb489;
   logic [3:0] r;
   // ==========================================================
   // Line clock and traffic.
   initial
   begin
      rx_line_clock_in = 1'b0;
      r = 4'h0;
   end
   always #3 rx_line_clock_in = ~rx_line_clock_in;
   // Pins move on the edge opposite the sampling one, so each stands half a period around it.
   always @(posedge rx_line_clock_in or negedge rx_line_clock_in)
   begin
      if (rx_line_clock_in == clk_inv)
      begin
         r = run ? 4'($random(seed)) : 4'h0;
      end
   end
   // Each mark goes to one rail picked at random, so a rail pair is never high on both at once.
   assign rx_pos_rail_in = r[0] & r[1];
   assign rx_neg_rail_in = r[0] & ~r[1];
   assign rx_analog_pos_in = r[2] & r[3];
   assign rx_analog_neg_in = r[2] & ~r[3];
   assign rx_unipolar_data_in = r[1];
   assign rx_code_violation_in = r[3] ^ lcv_idle;
endmodule
`default_nettype wire

// ---- test/line_side_digital_port_io_bench.sv ----
// Self-checking bench for the line-side pin block: APB control, transmit pins, receive pins.
// Assumes the far-side model in line_partner and the package and constants header of the design.
`timescale 1ns/1ps
`default_nettype none
`include "line_io_params.svh"
module line_side_digital_port_io_bench;
   import line_io_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, tx_pos_in = 1'b0, tx_neg_in = 1'b0, tx_bit_take;
   logic tx_pos_rail_out, tx_neg_rail_out, tx_line_clock_out, tx_unipolar_data_out;
   logic tx_analog_pos_out, tx_analog_neg_out, rx_serial_data_out;
   wire rx_line_clock_in, rx_pos_rail_in, rx_neg_rail_in, rx_analog_pos_in;
   wire rx_analog_neg_in, rx_unipolar_data_in, rx_code_violation_in;
   logic run = 1'b0, tx_on = 1'b0, rx_on = 1'b0, h1 = 1'b0, smp = 1'b0, ce = 1'b1;
   cfg_s cfg = 8'h00;
   integer seed = 32'hd6dcb489, fails = 0, checks = 0, cycles = 0, viol = 0;
   logic [7:0] modes [8] = '{8'h0e, 8'h3a, 8'hca, 8'h0b, 8'hfb, 8'h04, 8'h01, 8'hbe};
   logic [31:0] rd, c0;
   logic err;
   logic [2:0] tx_exp = 3'h0;
   logic [1:0] pick, hold;
   // ==========================================================
   // Design and far side.
   line_side_digital_port_io DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .tx_pos_in, .tx_neg_in, .tx_bit_take, .tx_pos_rail_out, .tx_neg_rail_out,
      .tx_line_clock_out, .tx_unipolar_data_out, .tx_analog_pos_out, .tx_analog_neg_out, .rx_line_clock_in,
      .rx_pos_rail_in, .rx_neg_rail_in, .rx_analog_pos_in, .rx_analog_neg_in, .rx_unipolar_data_in,
      .rx_code_violation_in, .rx_serial_data_out);
   line_partner partner (.run, .clk_inv(cfg.rx_clk_inv), .lcv_idle(cfg.rx_data_inv), .rx_line_clock_in,
      .rx_pos_rail_in, .rx_neg_rail_in, .rx_analog_pos_in, .rx_analog_neg_in, .rx_unipolar_data_in,
      .rx_code_violation_in);
   always #2.5 pclk = ~pclk;
   // ==========================================================
   // Checking helpers.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic exp_rx(input cfg_s c);
      if (!c.rx_serial_en)
         return 1'b0;
      if (c.unipolar_mode)
         return rx_unipolar_data_in ^ c.rx_data_inv;
      if (c.frontend_en)
         return rx_analog_pos_in | rx_analog_neg_in;
      return (rx_pos_rail_in ^ c.rx_data_inv) | (rx_neg_rail_in ^ c.rx_data_inv);
   endfunction
   // Pre-edge values are read, so the register update of this edge never races the check.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // ==========================================================
   // Transmit side: new random pair after each take, outputs checked while the take pulse stands.
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         wrap_up;
      end
      if (tx_bit_take === 1'b1)
      begin
         if (tx_on)
         begin
            chk({tx_pos_rail_out, tx_neg_rail_out}, (!cfg.unipolar_mode && cfg.tx_pins_en) ?
               {tx_pos_in, tx_neg_in} ^ {2{cfg.tx_data_inv}} : 2'b00);
            chk(tx_line_clock_out, cfg.tx_pins_en & ~cfg.tx_clk_inv);
            chk(tx_unipolar_data_out, cfg.unipolar_mode & cfg.tx_pins_en & (tx_pos_in ^ cfg.tx_data_inv));
            chk({tx_analog_pos_out, tx_analog_neg_out}, (!cfg.unipolar_mode && cfg.frontend_en) ?
               {tx_pos_in, tx_neg_in} : 2'b00);
         end
         tx_exp = {(!cfg.unipolar_mode && cfg.tx_pins_en) ? {tx_pos_in, tx_neg_in} ^ {2{cfg.tx_data_inv}} : 2'b00,
            cfg.unipolar_mode & cfg.tx_pins_en & (tx_pos_in ^ cfg.tx_data_inv)};
         pick = 2'($random(seed));
         tx_pos_in <= pick[0] & pick[1];
         tx_neg_in <= pick[0] & ~pick[1];
      end
   end
   // Far receiver samples on the clock pin's mid-bit edge, where the pins are settled.
   always @(tx_line_clock_out)
   begin
      if (tx_on && tx_line_clock_out === cfg.tx_clk_inv)
         chk({tx_pos_rail_out, tx_neg_rail_out, tx_unipolar_data_out}, tx_exp);
   end
   // ==========================================================
   // Receive side: sample on the selected edge, expect the bit two rising edges on.
   always @(posedge rx_line_clock_in or negedge rx_line_clock_in)
   begin
      if (rx_line_clock_in)
      begin
         if (rx_on)
            chk(rx_serial_data_out, h1);
         h1 = smp;
      end
      if (rx_line_clock_in != cfg.rx_clk_inv)
      begin
         smp = exp_rx(cfg);
         if (cfg.unipolar_mode)
            viol += rx_code_violation_in ^ cfg.rx_data_inv;
      end
   end
   // ==========================================================
   // Scenarios.
   task automatic run_mode(input logic [7:0] c);
      logic [31:0] r;
      integer v0;
      tx_on = 1'b0;
      rx_on = 1'b0;
      apb(1'b1, `ADDR_CTRL, {24'h0, c}, r, err);
      cfg = c;
      apb(1'b0, `ADDR_CTRL, 32'h0, r, err);
      chk(r, {24'h0, c});
      repeat (20) @(posedge pclk);
      apb(1'b0, `ADDR_VIOL_COUNT, 32'h0, r, err);
      v0 = viol;
      run = 1'b1;
      tx_on = 1'b1;
      rx_on = 1'b1;
      repeat (200) @(posedge pclk);
      run = 1'b0;
      repeat (20) @(posedge pclk);
      // With the enable low the clock pin and take pulse must hold still.
      ce <= 1'b0;
      @(posedge pclk);
      hold = {tx_line_clock_out, tx_bit_take};
      repeat (4) @(posedge pclk);
      chk({tx_line_clock_out, tx_bit_take}, hold);
      ce <= 1'b1;
      apb(1'b0, `ADDR_VIOL_COUNT, 32'h0, c0, err);
      chk(c0, {16'h0, 16'(r + viol - v0)});
   endtask
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ADDR_CTRL, 32'h0, rd, err);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0, rd, err);
      chk({err, rd[30:0]}, 32'h80000000);
      foreach (modes[i])
         run_mode(modes[i]);
      repeat (2)
         run_mode(8'($random(seed)));
      apb(1'b1, `ADDR_VIOL_COUNT, 32'hffff, rd, err);
      apb(1'b0, `ADDR_VIOL_COUNT, 32'h0, rd, err);
      chk(rd, c0);
      wrap_up;
   end
endmodule
`default_nettype wire
